// ===== hdl/pvr_pkg.sv
// Constants shared by the counter-array module value register block.
package pvr_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_MODULES = 6;
  localparam int BYTE_W      = 8;
  localparam int VALUE_W     = 16;
  localparam int IDX_W       = 3;
  localparam int ADDR_W      = 8;
  localparam int LOW_LSB     = 0;
  localparam int HIGH_LSB    = 8;

  // ****************************************************************
  // Register addresses on the special-function-register bus
  // ****************************************************************
  localparam logic [ADDR_W-1:0] MODULE0_VALUE_LOW  = 8'hfb;
  localparam logic [ADDR_W-1:0] MODULE0_VALUE_HIGH = 8'hfc;
  localparam logic [ADDR_W-1:0] MODULE1_VALUE_LOW  = 8'he9;
  localparam logic [ADDR_W-1:0] MODULE1_VALUE_HIGH = 8'hea;
  localparam logic [ADDR_W-1:0] MODULE2_VALUE_LOW  = 8'heb;
  localparam logic [ADDR_W-1:0] MODULE2_VALUE_HIGH = 8'hec;
  localparam logic [ADDR_W-1:0] MODULE3_VALUE_LOW  = 8'hed;
  localparam logic [ADDR_W-1:0] MODULE3_VALUE_HIGH = 8'hee;
  localparam logic [ADDR_W-1:0] MODULE4_VALUE_LOW  = 8'hfd;
  localparam logic [ADDR_W-1:0] MODULE4_VALUE_HIGH = 8'hfe;
  localparam logic [ADDR_W-1:0] MODULE5_VALUE_LOW  = 8'hce;
  localparam logic [ADDR_W-1:0] MODULE5_VALUE_HIGH = 8'hcf;

  localparam logic [ADDR_W-1:0] LOW_ADDR [NUM_MODULES] = '{
    MODULE0_VALUE_LOW, MODULE1_VALUE_LOW, MODULE2_VALUE_LOW,
    MODULE3_VALUE_LOW, MODULE4_VALUE_LOW, MODULE5_VALUE_LOW};
  localparam logic [ADDR_W-1:0] HIGH_ADDR [NUM_MODULES] = '{
    MODULE0_VALUE_HIGH, MODULE1_VALUE_HIGH, MODULE2_VALUE_HIGH,
    MODULE3_VALUE_HIGH, MODULE4_VALUE_HIGH, MODULE5_VALUE_HIGH};

  // ****************************************************************
  // Reset values and special modules
  // ****************************************************************
  localparam logic [VALUE_W-1:0] VALUE_RESET     = 16'h0000;
  localparam logic               CFE_RESET       = 1'b0;
  localparam logic [BYTE_W-1:0]  READ_IDLE       = 8'h00;
  localparam logic [IDX_W-1:0]   WATCHDOG_MODULE = 3'h5;

endpackage

// ===== hdl/pvr_addr_dec.sv
// Address decoder that maps a bus address to a module index and byte.
`timescale 1ns/10ps
module pvr_addr_dec (
  input  wire logic [pvr_pkg::ADDR_W-1:0] addr,
  output logic                            hit,
  output logic [pvr_pkg::IDX_W-1:0]       idx,
  output logic                            is_high
);

  always_comb begin
    hit     = 1'b0;
    idx     = '0;
    is_high = 1'b0;
    for (int i = 0; i < pvr_pkg::NUM_MODULES; i++) begin
      if (addr == pvr_pkg::LOW_ADDR[i]) begin
        hit     = 1'b1;
        idx     = pvr_pkg::IDX_W'(i);
        is_high = 1'b0;
      end else if (addr == pvr_pkg::HIGH_ADDR[i]) begin
        hit     = 1'b1;
        idx     = pvr_pkg::IDX_W'(i);
        is_high = 1'b1;
      end
    end
  end

endmodule

// ===== hdl/pvr_channel.sv
// One module's compare value, auto-reload value and comparator enable.
`timescale 1ns/10ps
module pvr_channel (
  input  wire logic                             clk,
  input  wire logic                             resetn,
  input  wire logic                             wr_low,
  input  wire logic                             wr_high,
  input  wire logic                             reload_sel,
  input  wire logic [pvr_pkg::BYTE_W-1:0]       wdata,
  input  wire logic                             mode_wr,
  input  wire logic                             mode_cfe,
  input  wire logic                             cfe_lock,
  output logic      [pvr_pkg::VALUE_W-1:0]      compare_value,
  output logic      [pvr_pkg::VALUE_W-1:0]      reload_value,
  output logic                                  cfe
);

  logic [pvr_pkg::VALUE_W-1:0] cmp_r;
  logic [pvr_pkg::VALUE_W-1:0] cmp_nxt;
  logic [pvr_pkg::VALUE_W-1:0] rld_r;
  logic [pvr_pkg::VALUE_W-1:0] rld_nxt;
  logic                        cfe_r;
  logic                        cfe_nxt;

  always_comb begin
    cmp_nxt  = cmp_r;
    rld_nxt  = rld_r;
    cfe_nxt  = cfe_r;
    if (wr_low) begin
      // [R03] select reload low
      if (reload_sel) begin
        rld_nxt[pvr_pkg::LOW_LSB +: pvr_pkg::BYTE_W] = wdata;
      end else begin
        // [R01] store low byte
        cmp_nxt[pvr_pkg::LOW_LSB +: pvr_pkg::BYTE_W] = wdata;
      end
      // [R06] low write clears
      if (!cfe_lock) begin
        cfe_nxt = 1'b0;
      end
    end else if (wr_high) begin
      // [R04] select reload high
      if (reload_sel) begin
        rld_nxt[pvr_pkg::HIGH_LSB +: pvr_pkg::BYTE_W] = wdata;
      end else begin
        // [R02] store high byte
        cmp_nxt[pvr_pkg::HIGH_LSB +: pvr_pkg::BYTE_W] = wdata;
      end
      // [R07] high write sets
      if (!cfe_lock) begin
        cfe_nxt = 1'b1;
      end
    end else if (mode_wr && !cfe_lock) begin
      cfe_nxt = mode_cfe;
    end
  end

  // [R10] zero reset, same-edge update
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cmp_r  <= pvr_pkg::VALUE_RESET;
      rld_r  <= pvr_pkg::VALUE_RESET;
      cfe_r  <= pvr_pkg::CFE_RESET;
    end else begin
      cmp_r  <= cmp_nxt;
      rld_r  <= rld_nxt;
      cfe_r  <= cfe_nxt;
    end
  end

  assign compare_value = cmp_r;
  assign reload_value  = rld_r;
  // [R08] enable gates compare
  assign cfe           = cfe_r;

endmodule

// ===== hdl/pvr_value_regs.sv
// Value byte registers of the six counter-array capture/compare modules.
`timescale 1ns/10ps
// How it works
// [R01] Low byte register holds compare value bits 7:0, read and write.
// [R02] High byte register holds compare value bits 15:8, read and write.
// [R03] Low byte address alternatively reaches the auto-reload low byte for PWM.
// [R04] High byte address alternatively reaches the auto-reload high byte for PWM.
// [R05] Reload select bit steers both addresses to compare or reload value.
// [R06] Writing a low byte register clears that module's comparator enable; module 5 keeps its enable while the watchdog is enabled.
// [R07] Writing a high byte register sets that module's comparator enable; module 5 keeps its enable while the watchdog is enabled.
// [R08] Comparator enable high turns the module's compare function on.
// [R09] With watchdog enabled, module 5 mode writes are ignored.
// [R10] All value bytes reset to zero; enable side effects land with the write.
module pvr_value_regs (
  input  wire logic                                              clk,
  input  wire logic                                              resetn,
  input  wire logic [pvr_pkg::ADDR_W-1:0]                        sfr_addr,
  input  wire logic [pvr_pkg::BYTE_W-1:0]                        sfr_wdata,
  input  wire logic                                              sfr_wr,
  input  wire logic                                              sfr_rd,
  input  wire logic                                              reload_register_select,
  input  wire logic                                              watchdog_enable_bit,
  input  wire logic [pvr_pkg::NUM_MODULES-1:0]                   mode_wr,
  input  wire logic                                              mode_wdata_cfe,
  output logic      [pvr_pkg::BYTE_W-1:0]                        sfr_rdata,
  output logic                                                   sfr_rdata_valid,
  output logic      [pvr_pkg::NUM_MODULES-1:0]                   comparator_function_enable,
  output logic      [pvr_pkg::NUM_MODULES*pvr_pkg::VALUE_W-1:0]  module_compare_value,
  output logic      [pvr_pkg::NUM_MODULES*pvr_pkg::VALUE_W-1:0]  auto_reload_value
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic                            dec_hit;
  logic [pvr_pkg::IDX_W-1:0]       dec_idx;
  logic                            dec_high;
  logic [pvr_pkg::NUM_MODULES-1:0] wr_low_vec;
  logic [pvr_pkg::NUM_MODULES-1:0] wr_high_vec;
  logic [pvr_pkg::NUM_MODULES-1:0] cfe_lock_vec;
  logic                            wr_low;
  logic                            wr_high;

  pvr_addr_dec u_dec (
    .addr    (sfr_addr),
    .hit     (dec_hit),
    .idx     (dec_idx),
    .is_high (dec_high)
  );

  assign wr_low  = sfr_wr && dec_hit && !dec_high;
  assign wr_high = sfr_wr && dec_hit && dec_high;

  always_comb begin
    wr_low_vec    = '0;
    wr_high_vec   = '0;
    cfe_lock_vec  = '0;
    for (int i = 0; i < pvr_pkg::NUM_MODULES; i++) begin
      wr_low_vec[i]  = wr_low && (dec_idx == pvr_pkg::IDX_W'(i));
      wr_high_vec[i] = wr_high && (dec_idx == pvr_pkg::IDX_W'(i));
      // [R09] watchdog locks module 5
      // The enable lives in the module's mode register, so the lock also
      // freezes the enable side effects of value writes while it holds.
      cfe_lock_vec[i] = watchdog_enable_bit
                         && (pvr_pkg::IDX_W'(i) == pvr_pkg::WATCHDOG_MODULE);
    end
  end

  // ****************************************************************
  // Per-module storage
  // ****************************************************************
  logic [pvr_pkg::VALUE_W-1:0] cmp_view [pvr_pkg::NUM_MODULES];
  logic [pvr_pkg::VALUE_W-1:0] rld_view [pvr_pkg::NUM_MODULES];

  for (genvar g = 0; g < pvr_pkg::NUM_MODULES; g++) begin : g_mod
    // [R08] enable gates compare
    // [R05] reload select steers writes
    pvr_channel u_chan (
      .clk           (clk),
      .resetn        (resetn),
      .wr_low        (wr_low_vec[g]),
      .wr_high       (wr_high_vec[g]),
      .reload_sel    (reload_register_select),
      .wdata         (sfr_wdata),
      .mode_wr       (mode_wr[g]),
      .mode_cfe      (mode_wdata_cfe),
      .cfe_lock      (cfe_lock_vec[g]),
      .compare_value (cmp_view[g]),
      .reload_value  (rld_view[g]),
      .cfe           (comparator_function_enable[g])
    );
    assign module_compare_value[g*pvr_pkg::VALUE_W +: pvr_pkg::VALUE_W] = cmp_view[g];
    assign auto_reload_value[g*pvr_pkg::VALUE_W +: pvr_pkg::VALUE_W]    = rld_view[g];
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Read data is registered, so it appears one cycle after the strobe.
  // Unmapped addresses leave the valid low so other registers may answer.
  logic [pvr_pkg::BYTE_W-1:0]  rdata_r;
  logic [pvr_pkg::BYTE_W-1:0]  rdata_nxt;
  logic                        rvalid_r;
  logic                        rvalid_nxt;

  always_comb begin
    logic [pvr_pkg::VALUE_W-1:0] src;
    src        = pvr_pkg::VALUE_RESET;
    rdata_nxt  = pvr_pkg::READ_IDLE;
    rvalid_nxt = sfr_rd && dec_hit;
    if (sfr_rd && dec_hit) begin
      for (int i = 0; i < pvr_pkg::NUM_MODULES; i++) begin
        if (dec_idx == pvr_pkg::IDX_W'(i)) begin
          // [R05] reload select steers reads
          src = reload_register_select ? rld_view[i] : cmp_view[i];
        end
      end
      // [R01] low and high byte reads
      rdata_nxt = dec_high ? src[pvr_pkg::HIGH_LSB +: pvr_pkg::BYTE_W]
                           : src[pvr_pkg::LOW_LSB +: pvr_pkg::BYTE_W];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata_r  <= pvr_pkg::READ_IDLE;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign sfr_rdata       = rdata_r;
  assign sfr_rdata_valid = rvalid_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_low_compare_write;
    @(posedge clk) disable iff (!resetn)
    (wr_low && !reload_register_select)
      |=> cmp_view[$past(dec_idx)][pvr_pkg::LOW_LSB +: pvr_pkg::BYTE_W] == $past(sfr_wdata);
  endproperty
  a_low_compare_write: assert property (p_low_compare_write) // [R01]
    else $error("Low byte write did not reach the compare value.");

  property p_high_compare_write;
    @(posedge clk) disable iff (!resetn)
    (wr_high && !reload_register_select)
      |=> cmp_view[$past(dec_idx)][pvr_pkg::HIGH_LSB +: pvr_pkg::BYTE_W] == $past(sfr_wdata);
  endproperty
  a_high_compare_write: assert property (p_high_compare_write) // [R02]
    else $error("High byte write did not reach the compare value.");

  property p_low_reload_write;
    @(posedge clk) disable iff (!resetn)
    (wr_low && reload_register_select)
      |=> rld_view[$past(dec_idx)][pvr_pkg::LOW_LSB +: pvr_pkg::BYTE_W] == $past(sfr_wdata);
  endproperty
  a_low_reload_write: assert property (p_low_reload_write) // [R03]
    else $error("Low byte write did not reach the reload value.");

  property p_high_reload_write;
    @(posedge clk) disable iff (!resetn)
    (wr_high && reload_register_select)
      |=> rld_view[$past(dec_idx)][pvr_pkg::HIGH_LSB +: pvr_pkg::BYTE_W] == $past(sfr_wdata);
  endproperty
  a_high_reload_write: assert property (p_high_reload_write) // [R04]
    else $error("High byte write did not reach the reload value.");

  property p_select_isolates;
    @(posedge clk) disable iff (!resetn)
    (sfr_wr && dec_hit && reload_register_select) |=> $stable(module_compare_value);
  endproperty
  a_select_isolates: assert property (p_select_isolates) // [R05]
    else $error("Reload write disturbed a compare value.");

  property p_low_clears_enable;
    @(posedge clk) disable iff (!resetn)
    (wr_low && !cfe_lock_vec[dec_idx])
      |=> !comparator_function_enable[$past(dec_idx)];
  endproperty
  a_low_clears_enable: assert property (p_low_clears_enable) // [R06]
    else $error("Low byte write left the comparator enabled.");

  property p_high_sets_enable;
    @(posedge clk) disable iff (!resetn)
    (wr_high && !cfe_lock_vec[dec_idx])
      |=> comparator_function_enable[$past(dec_idx)];
  endproperty
  a_high_sets_enable: assert property (p_high_sets_enable) // [R07]
    else $error("High byte write left the comparator disabled.");

  property p_enable_holds;
    @(posedge clk) disable iff (!resetn)
    (!(sfr_wr && dec_hit) && (mode_wr == '0)) |=> $stable(comparator_function_enable);
  endproperty
  a_enable_holds: assert property (p_enable_holds) // [R08]
    else $error("Comparator enable changed with no write.");

  property p_watchdog_lock;
    @(posedge clk) disable iff (!resetn)
    watchdog_enable_bit
      |=> $stable(comparator_function_enable[pvr_pkg::WATCHDOG_MODULE]);
  endproperty
  a_watchdog_lock: assert property (p_watchdog_lock) // [R09]
    else $error("Module 5 enable changed while the watchdog ran.");

  property p_reset_zero;
    @(posedge clk)
    !resetn |=> (module_compare_value == '0) && (auto_reload_value == '0)
                && (comparator_function_enable == '0);
  endproperty
  a_reset_zero: assert property (p_reset_zero) // [R10]
    else $error("Registers not zero after reset.");

  property p_read_back;
    @(posedge clk) disable iff (!resetn)
    (wr_high && !reload_register_select)
      ##1 (sfr_rd && !reload_register_select && (sfr_addr == $past(sfr_addr)))
      |=> sfr_rdata_valid && (sfr_rdata == $past(sfr_wdata, 2));
  endproperty
  a_read_back: assert property (p_read_back) // [R02]
    else $error("High byte read did not return the written byte.");

  // Bytes must be independent, as software may write them in any order.
  property p_low_keeps_high;
    @(posedge clk) disable iff (!resetn)
    (wr_low && !reload_register_select)
      |=> cmp_view[$past(dec_idx)][pvr_pkg::HIGH_LSB +: pvr_pkg::BYTE_W]
          == $past(cmp_view[dec_idx][pvr_pkg::HIGH_LSB +: pvr_pkg::BYTE_W]);
  endproperty
  a_low_keeps_high: assert property (p_low_keeps_high) // [R01]
    else $error("Low byte write disturbed the high byte.");

  property p_high_keeps_low;
    @(posedge clk) disable iff (!resetn)
    (wr_high && !reload_register_select)
      |=> cmp_view[$past(dec_idx)][pvr_pkg::LOW_LSB +: pvr_pkg::BYTE_W]
          == $past(cmp_view[dec_idx][pvr_pkg::LOW_LSB +: pvr_pkg::BYTE_W]);
  endproperty
  a_high_keeps_low: assert property (p_high_keeps_low) // [R02]
    else $error("High byte write disturbed the low byte.");

  // The select bit steers each write to one value only.
  property p_compare_isolates_reload;
    @(posedge clk) disable iff (!resetn)
    (sfr_wr && dec_hit && !reload_register_select) |=> $stable(auto_reload_value);
  endproperty
  a_compare_isolates_reload: assert property (p_compare_isolates_reload) // [R05]
    else $error("Compare write disturbed a reload value.");

  // Reads return the value as it stood at the strobe, even under a same-cycle write.
  property p_read_low_compare;
    @(posedge clk) disable iff (!resetn)
    (sfr_rd && dec_hit && !dec_high && !reload_register_select)
      |=> sfr_rdata_valid
          && (sfr_rdata == $past(cmp_view[dec_idx][pvr_pkg::LOW_LSB +: pvr_pkg::BYTE_W]));
  endproperty
  a_read_low_compare: assert property (p_read_low_compare) // [R01]
    else $error("Low byte read did not return the compare value.");

  property p_read_high_reload;
    @(posedge clk) disable iff (!resetn)
    (sfr_rd && dec_hit && dec_high && reload_register_select)
      |=> sfr_rdata_valid
          && (sfr_rdata == $past(rld_view[dec_idx][pvr_pkg::HIGH_LSB +: pvr_pkg::BYTE_W]));
  endproperty
  a_read_high_reload: assert property (p_read_high_reload) // [R04]
    else $error("High byte read did not return the reload value.");

  // Unmapped reads keep the valid low so that other registers may answer.
  property p_read_refused;
    @(posedge clk) disable iff (!resetn)
    (sfr_rd && !dec_hit) |=> !sfr_rdata_valid && (sfr_rdata == pvr_pkg::READ_IDLE);
  endproperty
  a_read_refused: assert property (p_read_refused) // [R05]
    else $error("Unmapped read returned data.");

  // The read port must leave reset idle, or a stale byte could be taken.
  property p_reset_read_idle;
    @(posedge clk)
    !resetn |=> !sfr_rdata_valid && (sfr_rdata == pvr_pkg::READ_IDLE);
  endproperty
  a_reset_read_idle: assert property (p_reset_read_idle) // [R10]
    else $error("Read port not idle after reset.");

  // ****************************************************************
  // Mode write port checks
  // ****************************************************************
  // A value write to the same module in the same cycle wins, so it is left out.
  for (genvar g = 0; g < pvr_pkg::NUM_MODULES; g++) begin : g_mode_chk
    property p_mode_write_enable;
      @(posedge clk) disable iff (!resetn)
      (mode_wr[g] && !wr_low_vec[g] && !wr_high_vec[g] && !cfe_lock_vec[g])
        |=> comparator_function_enable[g] == $past(mode_wdata_cfe);
    endproperty
    a_mode_write_enable: assert property (p_mode_write_enable) // [R08]
      else $error("Mode write did not reach the comparator enable.");
  end

endmodule

// ===== bench/pvr_cpu_model.sv
// CPU-side model that issues byte reads and writes on the register bus.
`timescale 1ns/10ps
module pvr_cpu_model (
  input  wire logic                         clk,
  output logic      [pvr_pkg::ADDR_W-1:0]   sfr_addr,
  output logic      [pvr_pkg::BYTE_W-1:0]   sfr_wdata,
  output logic                              sfr_wr,
  output logic                              sfr_rd,
  input  wire logic [pvr_pkg::BYTE_W-1:0]   sfr_rdata,
  input  wire logic                         sfr_rdata_valid
);
  initial begin
    sfr_addr  = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr    = 1'b0;
    sfr_rd    = 1'b0;
  end

  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  // Released lines show the inverse of the last value, so nothing stale can pass.
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clk);
    sfr_wr    <= 1'b0;
    sfr_addr  <= ~a;
    sfr_wdata <= ~d;
  endtask

  // The answer stands for one cycle only, so it is taken right after the taking edge.
  task automatic read(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge clk);
    sfr_rd   <= 1'b0;
    sfr_addr <= ~a;
    #1;
    d = sfr_rdata;
    v = sfr_rdata_valid;
  endtask
endmodule

// ===== bench/pvr_value_regs_tb.sv
// Self-checking testbench for the counter-array module value registers.
`timescale 1ns/10ps
module pvr_value_regs_tb;
  typedef struct packed {
    logic       sel;
    logic [2:0] m;
    logic       hi;
    logic [7:0] d;
    logic       e;
  } pvr_row_s;
  localparam pvr_row_s ROWS [12] = '{
    '{1'b0, 3'h0, 1'b1, 8'h12, 1'b1}, '{1'b0, 3'h0, 1'b0, 8'h34, 1'b0},
    '{1'b1, 3'h1, 1'b1, 8'hff, 1'b1}, '{1'b1, 3'h1, 1'b0, 8'h01, 1'b0},
    '{1'b0, 3'h2, 1'b0, 8'h80, 1'b0}, '{1'b1, 3'h2, 1'b1, 8'h7f, 1'b1},
    '{1'b0, 3'h3, 1'b1, 8'ha5, 1'b1}, '{1'b1, 3'h3, 1'b0, 8'h5a, 1'b0},
    '{1'b0, 3'h4, 1'b0, 8'hff, 1'b0}, '{1'b1, 3'h4, 1'b1, 8'hc3, 1'b1},
    '{1'b0, 3'h5, 1'b1, 8'h3c, 1'b1}, '{1'b1, 3'h5, 1'b0, 8'h96, 1'b0}};
  logic        clk;
  logic        resetn;
  logic        sel;
  logic        wdt;
  logic        cfe_d;
  logic [5:0]  mode_wr;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        rvalid;
  logic [5:0]  en;
  logic [95:0] cmpv;
  logic [95:0] rldv;
  logic [15:0] exp_cmp [6];
  logic [15:0] exp_rld [6];
  logic [5:0]  exp_en;
  int          failures;
  int          samples_checked;

  pvr_value_regs pvr_value_regs_i (.clk(clk), .resetn(resetn), .sfr_addr(addr),
    .sfr_wdata(wdata), .sfr_wr(wr), .sfr_rd(rd), .reload_register_select(sel),
    .watchdog_enable_bit(wdt), .mode_wr(mode_wr), .mode_wdata_cfe(cfe_d),
    .sfr_rdata(rdata), .sfr_rdata_valid(rvalid), .comparator_function_enable(en),
    .module_compare_value(cmpv), .auto_reload_value(rldv));
  pvr_cpu_model pvr_cpu_model_i (.clk(clk), .sfr_addr(addr), .sfr_wdata(wdata),
    .sfr_wr(wr), .sfr_rd(rd), .sfr_rdata(rdata), .sfr_rdata_valid(rvalid));

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  // ****************************************************************
  // Checking tasks
  // ****************************************************************
  task automatic check(input string name, input logic [95:0] seen, input logic [95:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check_all();
    logic [95:0] pc;
    logic [95:0] pr;
    #1;
    for (int i = 0; i < 6; i++) begin
      pc[16*i +: 16] = exp_cmp[i];
      pr[16*i +: 16] = exp_rld[i];
    end
    check("enable", {90'h0, en}, {90'h0, exp_en});
    check("compare value", cmpv, pc);
    check("reload value", rldv, pr);
  endtask

  task automatic clear_model();
    for (int i = 0; i < 6; i++) begin
      exp_cmp[i] = 16'h0000;
      exp_rld[i] = 16'h0000;
    end
    exp_en = 6'h00;
  endtask

  task automatic do_write(input int m, input logic hi, input logic [7:0] d);
    logic [15:0] v;
    pvr_cpu_model_i.write(hi ? pvr_pkg::HIGH_ADDR[m] : pvr_pkg::LOW_ADDR[m], d);
    v = sel ? exp_rld[m] : exp_cmp[m];
    if (hi) v[15:8] = d;
    else v[7:0] = d;
    if (sel) exp_rld[m] = v;
    else exp_cmp[m] = v;
    if (!(wdt && m == 5)) exp_en[m] = hi;
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp, input logic ev);
    logic [7:0] got;
    logic       gv;
    pvr_cpu_model_i.read(a, got, gv);
    check("read data", {88'h0, got}, {88'h0, exp});
    check("read valid", {95'h0, gv}, {95'h0, ev});
  endtask

  task automatic mode_pulse(input int m, input logic e);
    @(posedge clk);
    mode_wr <= 6'h01 << m;
    cfe_d   <= e;
    @(posedge clk);
    mode_wr <= 6'h00;
    cfe_d   <= ~e;
    if (!(wdt && m == 5)) exp_en[m] = e;
    check_all();
  endtask

  task automatic read_all();
    logic [15:0] v;
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      sel <= s[0];
      for (int m = 0; m < 6; m++) begin
        v = s ? exp_rld[m] : exp_cmp[m];
        rd_check(pvr_pkg::LOW_ADDR[m], v[7:0], 1'b1);
        rd_check(pvr_pkg::HIGH_ADDR[m], v[15:8], 1'b1);
      end
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    resetn   = 1'b0;
    sel      = 1'b0;
    wdt      = 1'b0;
    cfe_d    = 1'b0;
    mode_wr  = 6'h00;
    failures = 0;
    samples_checked = 0;
    clear_model();
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    check_all();
    read_all();
    foreach (ROWS[i]) begin
      @(posedge clk);
      sel <= ROWS[i].sel;
      do_write(ROWS[i].m, ROWS[i].hi, ROWS[i].d);
      check_all();
      check("row enable", {95'h0, en[ROWS[i].m]}, {95'h0, ROWS[i].e});
    end
    read_all();
    // Unmapped place: writes ignored, reads refused.
    pvr_cpu_model_i.write(8'hf9, 8'hee);
    check_all();
    rd_check(8'hf9, 8'h00, 1'b0);
    mode_pulse(2, 1'b1);
    mode_pulse(2, 1'b0);
    // A value write in the same cycle as a mode write wins.
    fork
      do_write(3, 1'b0, 8'h11);
      begin
        @(posedge clk);
        mode_wr <= 6'h08;
        cfe_d   <= 1'b1;
        @(posedge clk);
        mode_wr <= 6'h00;
      end
    join
    exp_en[3] = 1'b0;
    check_all();
    // Module 5 enable frozen while the watchdog runs.
    @(posedge clk);
    wdt <= 1'b1;
    mode_pulse(5, 1'b1);
    do_write(5, 1'b1, 8'h5a);
    check_all();
    @(posedge clk);
    wdt <= 1'b0;
    mode_pulse(5, 1'b1);
    // Second reset in mid-run clears everything again.
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    clear_model();
    check_all();
    read_all();
    report_and_stop();
  end

  initial begin
    #20000;
    failures++;
    report_and_stop();
  end
endmodule
